// [src/pmw_power_wake_ctrl.sv]
/*
  Power mode and wake-up controller: the paged registers, the four wake
  sources with sticky flags, the reset-pin wake flag, the awake/suspend/sleep
  state, and the clock-out, wake-request and supply-monitor controls.
  Assumes event inputs are asynchronous levels whose rising edge is an event,
  a low-going reset pin, and a register bus that writes and reads in one cycle.
*/
//
// Contract
// - Writing 1 to config bit 7 enters sleep; the bit reads nothing.
// - Writing 1 to config bit 6 enters suspend; write-only.
// - Writing 1 to config bit 5 clears all wake flags together.
// - Config bit 4 reads 1 after a falling edge on the reset pin.
// - Bit 3 writes oscillator-fail wake enable, reads oscillator-fail flag.
// - Bit 2 writes clock-alarm wake enable, reads alarm flag.
// - Bit 1 writes port-match wake enable, reads port-match flag.
// - Bit 0 writes comparator rising-edge wake enable, reads its flag.
// - Flags update on every event, enabled or not, awake or asleep.
// - Enables take effect from the same write that enters a mode.
// - Any set flag blocks suspend and sleep, keeps low-power oscillator on.
// - Flags read zero for two clocks after waking from suspend.
// - Mode bit 7 drives buffered low-frequency clock onto its pin.
// - Mode bit 6 enables the wake-request output pin.
// - Enabled wake request is high awake, low asleep, rises on wake.
// - Mode bit 5 disables supply monitor; clearing it while set causes reset.
// - Power control bits 7:2 are six read/write general flags.
// - Writing 1 to power control bit 1 enters stop mode; write-only.
// - Writing 1 to power control bit 0 enters idle mode; write-only.
// - Address B5 is config on page 0 and mode on page F.
// - Power control at 87 decodes on every page.
// - Reset-pin falling edge always wakes from sleep; cannot be disabled.
`timescale 1ns/1ps

module pmw_power_wake_ctrl
(
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RESET,
  input  wire logic [3:0] I_PAGE,
  input  wire logic [7:0] I_ADDR,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic [7:0] I_WDATA,
  input  wire logic [3:0] I_WAKE_EVENT,
  input  wire logic       I_RST_PIN_N,
  input  wire logic       I_LF_CLK,
  output logic      [7:0] O_RDATA,
  output logic            O_IDLE_REQ,
  output logic            O_STOP_REQ,
  output logic            O_SUSPEND,
  output logic            O_SLEEP,
  output logic            O_POR_REQ,
  output logic            O_MONITOR_DISABLE,
  output logic            O_LPO_KEEP_ON,
  output logic            O_LF_CLK_OUT,
  output logic            O_LF_CLK_OUT_OE_N,
  output logic            O_WAKE_REQ,
  output logic            O_WAKE_REQ_OE_N
);

  pmw_pkg::pmw_regs_t r_reg;
  pmw_pkg::pmw_regs_t r_next;

  logic       sel_cfg;
  logic       sel_mode;
  logic       sel_power_control;
  logic [3:0] ev_rise;
  logic       rst_fall;
  logic       any_flag;
  logic       wake_now;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  always_comb
  begin
    sel_power_control = (I_ADDR == pmw_pkg::ADDR_POWER_CONTROL);
    sel_cfg  = (I_ADDR == pmw_pkg::ADDR_WAKE_MODE) && (I_PAGE == pmw_pkg::PAGE_WAKE_CONFIG);
    sel_mode = (I_ADDR == pmw_pkg::ADDR_WAKE_MODE) && (I_PAGE == pmw_pkg::PAGE_UNIT_MODE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    r_next = r_reg;

    // Pins pass three flops; a change counts when the last two agree
    r_next.rst_sync = {r_reg.rst_sync[1:0], I_RST_PIN_N};
    if (r_reg.rst_sync[2] == r_reg.rst_sync[1])
    begin
      r_next.rst_level = r_reg.rst_sync[2];
    end
    rst_fall = r_reg.rst_level && (r_reg.rst_sync[2] == r_reg.rst_sync[1]) && !r_reg.rst_sync[2];

    r_next.ev_sync1 = I_WAKE_EVENT;
    r_next.ev_sync2 = r_reg.ev_sync1;
    r_next.ev_sync3 = r_reg.ev_sync2;
    for (int i = 0; i < pmw_pkg::NUM_SOURCES; i++)
    begin
      if (r_reg.ev_sync2[i] == r_reg.ev_sync3[i])
      begin
        r_next.ev_level[i] = r_reg.ev_sync3[i];
      end
      ev_rise[i] = !r_reg.ev_level[i] && (r_reg.ev_sync2[i] == r_reg.ev_sync3[i]) && r_reg.ev_sync3[i];
    end

    any_flag = (|r_reg.wake_flag) || r_reg.reset_pin_wake_flag;
    wake_now = (|(ev_rise & r_reg.wake_enable)) || rst_fall;

    r_next.idle_pulse = 1'b0;
    r_next.stop_pulse = 1'b0;
    r_next.por_pulse  = 1'b0;
    if (r_reg.blank_cnt != 2'h0)
    begin
      r_next.blank_cnt = r_reg.blank_cnt - 2'h1;
    end

    // Clear first so that an event in the same cycle still sets its flag
    if (I_WR && sel_cfg && I_WDATA[pmw_pkg::CFG_CLEAR_BIT])
    begin
      r_next.wake_flag           = pmw_pkg::FLAGS_RESET;
      r_next.reset_pin_wake_flag = 1'b0;
    end
    r_next.wake_flag = r_next.wake_flag | ev_rise;
    if (rst_fall)
    begin
      r_next.reset_pin_wake_flag = 1'b1;
    end

    case (r_reg.state)
      pmw_pkg::ST_AWAKE:
      begin
        if (I_WR && sel_cfg)
        begin
          r_next.wake_enable = I_WDATA[pmw_pkg::NUM_SOURCES-1:0];
          // Flags are checked before this write's clear takes hold
          if (!any_flag && I_WDATA[pmw_pkg::CFG_SLEEP_BIT])
          begin
            r_next.state = pmw_pkg::ST_SLEEP;
          end
          else if (!any_flag && I_WDATA[pmw_pkg::CFG_SUSPEND_BIT])
          begin
            r_next.state = pmw_pkg::ST_SUSPEND;
          end
        end
      end
      pmw_pkg::ST_SUSPEND:
      begin
        if (wake_now)
        begin
          r_next.state     = pmw_pkg::ST_AWAKE;
          r_next.blank_cnt = pmw_pkg::SUSPEND_BLANK_CYCLES;
        end
      end
      pmw_pkg::ST_SLEEP:
      begin
        if (wake_now)
        begin
          r_next.state = pmw_pkg::ST_AWAKE;
        end
      end
      default:
      begin
        r_next.state = pmw_pkg::ST_AWAKE;
      end
    endcase

    if (I_WR && sel_mode)
    begin
      r_next.lf_clock_out_enable     = I_WDATA[pmw_pkg::MODE_LFOUT_BIT];
      r_next.wake_request_out_enable = I_WDATA[pmw_pkg::MODE_WAKE_REQUEST_OUT_ENABLE_BIT];
      r_next.battery_monitor_disable = I_WDATA[pmw_pkg::MODE_BATTERY_MONITOR_DISABLE_BIT];
      if (r_reg.battery_monitor_disable && !I_WDATA[pmw_pkg::MODE_BATTERY_MONITOR_DISABLE_BIT])
      begin
        r_next.por_pulse = pmw_pkg::POR_PULSE_CYCLES[0];
      end
    end

    if (I_WR && sel_power_control)
    begin
      r_next.general_flags = I_WDATA[7:2];
      r_next.stop_pulse    = I_WDATA[pmw_pkg::POWER_CONTROL_STOP_BIT];
      r_next.idle_pulse    = I_WDATA[pmw_pkg::POWER_CONTROL_IDLE_BIT];
    end

    // Read data
    rd_mux = 8'h00;
    if (sel_power_control)
    begin
      rd_mux = {r_reg.general_flags, 2'b00};
    end
    else if (sel_cfg)
    begin
      if (r_reg.blank_cnt == 2'h0)
      begin
        rd_mux = {3'b000, r_reg.reset_pin_wake_flag, r_reg.wake_flag};
      end
    end
    else if (sel_mode)
    begin
      rd_mux = {r_reg.lf_clock_out_enable, r_reg.wake_request_out_enable,
                r_reg.battery_monitor_disable, 5'h00};
    end
    r_next.rdata = I_RD ? rd_mux : 8'h00;

    r_next.lf_clk_out   = r_reg.lf_clock_out_enable && I_LF_CLK;
    r_next.wake_req_out = (r_next.state != pmw_pkg::ST_SLEEP);
    r_next.lpo_keep_on  = (|r_next.wake_flag) || r_next.reset_pin_wake_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      r_reg                         <= '0;
      r_reg.state                   <= pmw_pkg::ST_AWAKE;
      r_reg.general_flags           <= pmw_pkg::GENERAL_FLAGS_RESET;
      r_reg.wake_flag               <= pmw_pkg::FLAGS_RESET;
      r_reg.rst_sync                <= 3'b111;
      r_reg.rst_level               <= 1'b1;
      r_reg.wake_req_out            <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb
  begin
    O_RDATA           = r_reg.rdata;
    O_IDLE_REQ        = r_reg.idle_pulse;
    O_STOP_REQ        = r_reg.stop_pulse;
    O_SUSPEND         = (r_reg.state == pmw_pkg::ST_SUSPEND);
    O_SLEEP           = (r_reg.state == pmw_pkg::ST_SLEEP);
    O_POR_REQ         = r_reg.por_pulse;
    O_MONITOR_DISABLE = r_reg.battery_monitor_disable;
    O_LPO_KEEP_ON     = r_reg.lpo_keep_on;
    O_LF_CLK_OUT      = r_reg.lf_clk_out;
    O_LF_CLK_OUT_OE_N = !r_reg.lf_clock_out_enable;
    O_WAKE_REQ        = r_reg.wake_req_out;
    O_WAKE_REQ_OE_N   = !r_reg.wake_request_out_enable;
  end

endmodule // pmw_power_wake_ctrl

// [src/pmw_pkg.sv]
/*
  Package for the power mode and wake-up control block: register addresses,
  pages, field positions, reset values, cycle counts and the state carrier.
  Assumes a paged 8-bit special-function register bus on one system clock.
*/
package pmw_pkg;

  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_WAKE_MODE     = 8'hB5;
  localparam logic [3:0] PAGE_WAKE_CONFIG   = 4'h0;
  localparam logic [3:0] PAGE_UNIT_MODE     = 4'hF;

  // Configuration register fields
  localparam int CFG_SLEEP_BIT   = 7;
  localparam int CFG_SUSPEND_BIT = 6;
  localparam int CFG_CLEAR_BIT   = 5;
  localparam int CFG_RSTPIN_BIT  = 4;
  localparam int NUM_SOURCES     = 4;

  // Mode register fields
  localparam int MODE_LFOUT_BIT  = 7;
  localparam int MODE_WAKE_REQUEST_OUT_ENABLE_BIT = 6;
  localparam int MODE_BATTERY_MONITOR_DISABLE_BIT = 5;

  // Power control fields
  localparam int POWER_CONTROL_STOP_BIT   = 1;
  localparam int POWER_CONTROL_IDLE_BIT   = 0;

  localparam logic [5:0] GENERAL_FLAGS_RESET = 6'h00;
  localparam logic [2:0] UNIT_MODE_RESET     = 3'h0;
  localparam logic [3:0] FLAGS_RESET         = 4'h0;

  // Flags read zero for this many system clocks after a suspend wake
  localparam logic [1:0] SUSPEND_BLANK_CYCLES = 2'h2;

  // Cycles from power-on-reset request through its pulse
  localparam logic [1:0] POR_PULSE_CYCLES     = 2'h1;

  typedef enum logic [2:0] {
    ST_AWAKE   = 3'b001,
    ST_SUSPEND = 3'b010,
    ST_SLEEP   = 3'b100
  } pmw_state_t;

  typedef struct packed {
    pmw_state_t       state;
    logic [5:0]       general_flags;
    logic             lf_clock_out_enable;
    logic             wake_request_out_enable;
    logic             battery_monitor_disable;
    logic [3:0]       wake_enable;
    logic [3:0]       wake_flag;
    logic             reset_pin_wake_flag;
    logic [1:0]       blank_cnt;
    logic [2:0]       rst_sync;
    logic             rst_level;
    logic [3:0]       ev_sync1;
    logic [3:0]       ev_sync2;
    logic [3:0]       ev_sync3;
    logic [3:0]       ev_level;
    logic [7:0]       rdata;
    logic             idle_pulse;
    logic             stop_pulse;
    logic             por_pulse;
    logic             lf_clk_out;
    logic             wake_req_out;
    logic             lpo_keep_on;
  } pmw_regs_t;

endpackage

// [tb/pmw_power_wake_ctrl_chk.sv]
/*
  Port checker for the power mode and wake-up controller.
  Assumes the paged register bus of the controller and one system clock.
*/
`timescale 1ns/1ps

module pmw_chk
(
  input wire logic       I_SYS_CLK,
  input wire logic       I_RESET,
  input wire logic [3:0] I_PAGE,
  input wire logic [7:0] I_ADDR,
  input wire logic       I_WR,
  input wire logic       I_RD,
  input wire logic [7:0] I_WDATA,
  input wire logic [7:0] O_RDATA,
  input wire logic       O_IDLE_REQ,
  input wire logic       O_STOP_REQ,
  input wire logic       O_SUSPEND,
  input wire logic       O_SLEEP,
  input wire logic       O_POR_REQ,
  input wire logic       O_MONITOR_DISABLE,
  input wire logic       O_LF_CLK_OUT_OE_N,
  input wire logic       O_WAKE_REQ,
  input wire logic       O_WAKE_REQ_OE_N
);
  wire pc_wr   = I_WR && I_ADDR == 8'h87;
  wire cfg_wr  = I_WR && I_ADDR == 8'hB5 && I_PAGE == 4'h0;
  wire mode_wr = I_WR && I_ADDR == 8'hB5 && I_PAGE == 4'hF;
  wire cfg_rd  = I_RD && I_ADDR == 8'hB5 && I_PAGE == 4'h0;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);

  //////////////////////////////////////////////////////////////////////////////
  a_idle_pulse: assert property (O_IDLE_REQ == $past(pc_wr && I_WDATA[0]))
    else $error("idle request does not follow its write");
  a_stop_pulse: assert property (O_STOP_REQ == $past(pc_wr && I_WDATA[1]))
    else $error("stop request does not follow its write");
  a_cfg_wo_zero: assert property (cfg_rd |=> O_RDATA[7:5] == 3'h0)
    else $error("write-only config bits read nonzero");
  a_sleep_entry: assert property ($rose(O_SLEEP) |-> $past(cfg_wr && I_WDATA[7]))
    else $error("sleep entered without a sleep write");
  a_suspend_entry: assert property ($rose(O_SUSPEND) |-> $past(cfg_wr && I_WDATA[6]))
    else $error("suspend entered without a suspend write");
  a_req_low_asleep: assert property (O_SLEEP |-> !O_WAKE_REQ)
    else $error("wake request high while asleep");
  a_req_rise_wake: assert property ($fell(O_SLEEP) |=> O_WAKE_REQ)
    else $error("wake request not high after wake");
  a_mode_fields: assert property (mode_wr |=> {O_LF_CLK_OUT_OE_N, O_WAKE_REQ_OE_N, O_MONITOR_DISABLE} ==
    {~$past(I_WDATA[7]), ~$past(I_WDATA[6]), $past(I_WDATA[5])})
    else $error("mode outputs do not follow mode write");
  a_por_cause: assert property (O_POR_REQ == $past(mode_wr && !I_WDATA[5] && O_MONITOR_DISABLE))
    else $error("power-on reset request mismatch");

  c_sleep: cover property ($rose(O_SLEEP));
  c_suspend_wake: cover property ($fell(O_SUSPEND));
  c_por: cover property (O_POR_REQ);
endmodule // pmw_chk

bind pmw_power_wake_ctrl pmw_chk u_chk (.I_SYS_CLK, .I_RESET, .I_PAGE, .I_ADDR, .I_WR, .I_RD, .I_WDATA, .O_RDATA,
  .O_IDLE_REQ, .O_STOP_REQ, .O_SUSPEND, .O_SLEEP, .O_POR_REQ, .O_MONITOR_DISABLE, .O_LF_CLK_OUT_OE_N, .O_WAKE_REQ,
  .O_WAKE_REQ_OE_N);

// [tb/tb_pmw_power_wake_ctrl.sv]
/*
  Directed bench for the power mode and wake-up controller.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) if ((got) !== (ex)) begin err_total++; $display("Error %s expected %h seen %h", nm, ex, got); end n_compared++;

module tb_pmw_power_wake_ctrl;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] page = 4'h0;
  logic [7:0] addr = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] ev = 4'h0;
  logic       pin_n = 1'b1;
  logic       lf = 1'b0;
  logic [7:0] rdata;
  logic       idle, stop, susp, slp, por, mdis, lpo, lfo, lfo_oe_n, wreq, wreq_oe_n;
  int         err_total = 0;
  int         n_compared = 0;
  int         i;

  pmw_power_wake_ctrl dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_PAGE(page), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
    .I_WDATA(wdata), .I_WAKE_EVENT(ev), .I_RST_PIN_N(pin_n), .I_LF_CLK(lf), .O_RDATA(rdata), .O_IDLE_REQ(idle),
    .O_STOP_REQ(stop), .O_SUSPEND(susp), .O_SLEEP(slp), .O_POR_REQ(por), .O_MONITOR_DISABLE(mdis),
    .O_LPO_KEEP_ON(lpo), .O_LF_CLK_OUT(lfo), .O_LF_CLK_OUT_OE_N(lfo_oe_n), .O_WAKE_REQ(wreq),
    .O_WAKE_REQ_OE_N(wreq_oe_n));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Every drive lands 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr8(input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
    page = p;
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask

  task automatic rd8(input logic [3:0] p, input logic [7:0] a, input logic [7:0] ex);
    page = p;
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    `CHK("rdata", ex, rdata)
    // Let an edge pass so a following read never re-raises the strobe in this time step
    cyc(1);
  endtask

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded wait: a wake that never comes ends the run
  task automatic wait_awake();
    for (i = 0; i < 20 && (slp | susp) !== 1'b0; i++)
      cyc(1);
    if (i == 20)
    begin
      err_total++;
      $display("Error wake expected 0 seen 1");
      test_done();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(16);
    rst = 1'b0;
    `CHK("oe_n", 2'b11, {lfo_oe_n, wreq_oe_n})
    rd8(4'h5, 8'h87, 8'h00);
    rd8(4'hF, 8'hB5, 8'h00);
    rd8(4'h0, 8'hB5, 8'h00);
    $display("Test reset values done");
    wr8(4'h3, 8'h87, 8'hFD);
    `CHK("idle", 2'b01, {stop, idle})
    rd8(4'hA, 8'h87, 8'hFC);
    wr8(4'h0, 8'h87, 8'h56);
    `CHK("stop", 2'b10, {stop, idle})
    rd8(4'hF, 8'h87, 8'h54);
    $display("Test power control done");
    lf = 1'b1;
    wr8(4'hF, 8'hB5, 8'hFF);
    `CHK("mode", 3'b001, {lfo_oe_n, wreq_oe_n, mdis})
    rd8(4'hF, 8'hB5, 8'hE0);
    `CHK("lf_out", 1'b1, lfo)
    rd8(4'h0, 8'hB5, 8'h00);
    wr8(4'hF, 8'hB5, 8'h40);
    `CHK("por", 2'b10, {por, mdis})
    cyc(2);
    `CHK("lf_off", 1'b0, lfo)
    $display("Test mode register done");
    for (int s = 0; s < 4; s++)
    begin
      ev = 4'h1 << s;
      cyc(6);
      rd8(4'h0, 8'hB5, 8'h01 << s);
      `CHK("lpo", 1'b1, lpo)
      wr8(4'h0, 8'hB5, 8'hA0);
      `CHK("blocked", 1'b0, slp)
      ev = 4'h0;
      cyc(6);
      wr8(4'h0, 8'hB5, 8'h20);
      rd8(4'h0, 8'hB5, 8'h00);
    end
    $display("Test flags done");
    wr8(4'h0, 8'hB5, 8'h84);
    `CHK("sleep", 2'b10, {slp, wreq})
    ev = 4'h2;
    cyc(8);
    `CHK("asleep", 1'b1, slp)
    ev = 4'h6;
    wait_awake();
    cyc(1);
    `CHK("wake_req", 1'b1, wreq)
    rd8(4'h0, 8'hB5, 8'h06);
    ev = 4'h0;
    cyc(6);
    wr8(4'h0, 8'hB5, 8'h20);
    cyc(1);
    wr8(4'h0, 8'hB5, 8'h80);
    `CHK("sleep2", 1'b1, slp)
    pin_n = 1'b0;
    wait_awake();
    pin_n = 1'b1;
    rd8(4'h0, 8'hB5, 8'h10);
    $display("Test sleep done");
    cyc(6);
    wr8(4'h0, 8'hB5, 8'h20);
    cyc(1);
    wr8(4'h0, 8'hB5, 8'h41);
    `CHK("suspend", 1'b1, susp)
    ev = 4'h1;
    wait_awake();
    rd8(4'h0, 8'hB5, 8'h00);
    cyc(3);
    rd8(4'h0, 8'hB5, 8'h01);
    $display("Test suspend done");
    test_done();
  end
endmodule // tb_pmw_power_wake_ctrl
